// *** hdl/scb_defs.svh ***
`ifndef SCB_DEFS_SVH
`define SCB_DEFS_SVH

// Register indices, taken from the low seven bits of the command byte
`define SCB_IDX_PLL_MODE     7'h00
`define SCB_IDX_OE_LOW       7'h01
`define SCB_IDX_OE_HIGH      7'h02
`define SCB_IDX_PIN_RB       7'h03
`define SCB_IDX_RSVD         7'h04
`define SCB_IDX_BYTE_COUNT   7'h07

// Command byte fields
`define SCB_CMD_MODE_BIT     7

// Field positions in the PLL mode register
`define SCB_FREQ_BIT         0
`define SCB_HI_EN_LSB        3
`define SCB_HI_EN_MSB        5
`define SCB_PLL_LSB          6
`define SCB_PLL_MSB          7

// Reset values
`define SCB_OE_BYTE_RST      8'hFF
`define SCB_HI_EN_RST        3'h7
`define SCB_BC_RST           5'h08

// Output range gated by the enable pins, and the total output count
`define SCB_PIN_GATED_LO     5
`define SCB_PIN_GATED_HI     12
`define SCB_NUM_OUTS         19

// Bit counter marks
`define SCB_LAST_BIT         4'h7
`define SCB_ACK_SLOT         4'h8
`define SCB_PRE_FIRST        4'hF

`endif

// *** hdl/scb_pkg.sv ***
package scb_pkg;

   // Bus engine states
   typedef enum logic [2:0]
   {
      SCB_IDLE,
      SCB_ADDR,
      SCB_CMD,
      SCB_WCOUNT,
      SCB_WDATA,
      SCB_TX
   } scb_state_t;

   // Software-writable control image
   typedef struct packed
   {
      logic [4:0] byte_count;
      logic [2:0] hi_en;
      logic [7:0] oe_high;
      logic [7:0] oe_low;
   } scb_ctrl_t;

   // Straps caught at power-good
   typedef struct packed
   {
      logic [1:0] pll_mode;
      logic       freq_sel;
   } scb_strap_t;

endpackage

// *** hdl/scb_regs.sv ***
// Notes on behaviour
// - Command bit 7: one byte, zero block
// - Block mode: next byte is the count
// - Byte read: repeated start, host NAKs last
// - Block read command acked as start index
// - Block read sends count, then data bytes
// - Low seven command bits give start index
// - Command zero starts block at register 0
// - Every received write byte is acknowledged
// - Block write ends with ack then stop
// - Reg 0 bit 0 returns latched frequency strap
// - Reg 0 bits 7:6 return latched PLL mode
// - Reg 0 bits 5:3 enable outputs 16-18
// - Reg 3 reads enable pins in real time
// - Reg 4 reserved, reads zero
// - PLL code 00 low, 01 bypass, 11 high
// - Outputs 5-12 need bit set, pin low
// - Power-down releases bus, keeps registers
// - Byte count register sets read length, default 8
`timescale 1ns/1ns
`default_nettype none
`include "scb_defs.svh"

module scb_regs
(
   // Clock, reset, enable
   input  wire logic                 mclk_i,
   input  wire logic                 rst_n_i,
   input  wire logic                 ce_i,
   // Serial management bus pins
   input  wire logic                 scl_i,
   input  wire logic                 sda_i,
   output logic                      sda_o,
   output logic                      sda_oe_o,
   input  wire logic [6:0]           dev_addr_i,
   // Straps, power and output-enable pins
   input  wire logic                 power_good_strobe_i,
   input  wire logic                 freq_select_strap_i,
   input  wire logic [1:0]           pll_bandwidth_strap_i,
   input  wire logic [7:0]           oe_pin_n_i,
   // Output stage controls
   output logic [18:0]               diff_clock_output_en_o,
   output scb_pkg::scb_strap_t       strap_o
);
   import scb_pkg::*;

   logic [13:0] sync1_reg;
   logic [13:0] sync2_reg;
   logic        scl_d_reg;
   logic        sda_d_reg;
   logic        pg_d_reg;
   logic        strap_done_reg;
   scb_strap_t  strap_reg;
   scb_ctrl_t   ctrl_reg;
   scb_state_t  state_reg;
   logic [3:0]  bit_cnt_reg;
   logic [7:0]  shift_reg;
   logic [7:0]  tx_reg;
   logic [6:0]  idx_reg;
   logic        byte_mode_reg;
   logic        ack_ours_reg;
   logic        mack_reg;
   logic        sda_oe_reg;
   logic [18:0] out_en_reg;
   logic [18:0] out_en_next;
   logic [7:0]  rd_byte;

   logic       scl_s;
   logic       sda_s;
   logic       pg_s;
   logic [7:0] pin_s;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_det;
   logic       stop_det;
   logic       byte_end;
   logic       ack_end;
   logic       addr_hit;
   logic [7:0] count_byte;

   // Read decode, used by the first byte-mode read load and by following loads
   function automatic logic [7:0] reg_read(input logic [6:0] idx, input scb_strap_t st,
                                           input scb_ctrl_t c, input logic [7:0] pins);
      logic [7:0] v;
      v = 8'h00;
      unique case (idx)
         `SCB_IDX_PLL_MODE:   v = {st.pll_mode, c.hi_en, 2'b00, st.freq_sel};
         `SCB_IDX_OE_LOW:     v = c.oe_low;
         `SCB_IDX_OE_HIGH:    v = c.oe_high;
         `SCB_IDX_PIN_RB:     v = pins;
         `SCB_IDX_BYTE_COUNT: v = {3'b000, c.byte_count};
         default:             v = 8'h00;
      endcase
      return v;
   endfunction

   // Two-stage synchroniser for the bus, power-good, strap and output-enable pins
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         sync1_reg <= 14'h0003;
         sync2_reg <= 14'h0003;
      end
      else if (ce_i)
      begin
         sync1_reg <= {oe_pin_n_i, pll_bandwidth_strap_i, freq_select_strap_i,
                       power_good_strobe_i, sda_i, scl_i};
         sync2_reg <= sync1_reg;
      end
   end

   assign scl_s = sync2_reg[0];
   assign sda_s = sync2_reg[1];
   assign pg_s  = sync2_reg[2];
   assign pin_s = sync2_reg[13:6];

   // Delayed copies for edge and condition detection
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
         pg_d_reg  <= 1'b0;
      end
      else if (ce_i)
      begin
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
         pg_d_reg  <= pg_s;
      end
   end

   // Bus is ignored entirely while power is down
   assign scl_rise  = ce_i && pg_s && scl_s && !scl_d_reg;
   assign scl_fall  = ce_i && pg_s && !scl_s && scl_d_reg;
   assign start_det = ce_i && pg_s && scl_s && scl_d_reg && !sda_s && sda_d_reg;
   assign stop_det  = ce_i && pg_s && scl_s && scl_d_reg && sda_s && !sda_d_reg;
   assign byte_end  = scl_fall && (bit_cnt_reg == `SCB_LAST_BIT) && (state_reg != SCB_IDLE);
   assign ack_end   = scl_fall && (bit_cnt_reg == `SCB_ACK_SLOT) && (state_reg != SCB_IDLE);
   assign addr_hit  = (shift_reg[7:1] == dev_addr_i);
   // A zero count register would be illegal on the wire, so send one instead
   assign count_byte = (ctrl_reg.byte_count == 5'h00) ? 8'h01 : {3'b000, ctrl_reg.byte_count};
   // Readback of the register under the current index
   assign rd_byte    = reg_read(idx_reg, strap_reg, ctrl_reg, pin_s);

   // Straps caught once, on the first power-good rise only
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         strap_done_reg <= 1'b0;
         strap_reg      <= '0;
      end
      else if (ce_i && pg_s && !pg_d_reg && !strap_done_reg)
      begin
         strap_done_reg     <= 1'b1;
         strap_reg.freq_sel <= sync2_reg[3];
         strap_reg.pll_mode <= sync2_reg[5:4];
      end
   end

   assign strap_o = strap_reg;

   // Bit counter, framed by start and stop
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         bit_cnt_reg <= 4'h0;
      // Start parks below zero, so the clock fall right after it is not a bit
      else if (start_det)
         bit_cnt_reg <= `SCB_PRE_FIRST;
      else if (stop_det)
         bit_cnt_reg <= 4'h0;
      else if (ack_end)
         bit_cnt_reg <= 4'h0;
      else if (scl_fall && state_reg != SCB_IDLE)
         bit_cnt_reg <= bit_cnt_reg + 4'h1;
   end

   // Receive shifter samples on the rising clock edge
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         shift_reg <= 8'h00;
         mack_reg  <= 1'b0;
      end
      else if (scl_rise)
      begin
         if (bit_cnt_reg < `SCB_ACK_SLOT)
            shift_reg <= {shift_reg[6:0], sda_s};
         else
            mack_reg <= !sda_s;
      end
   end

   // Protocol engine: states, index, transmit byte and data line
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_reg     <= SCB_IDLE;
         idx_reg       <= 7'h00;
         byte_mode_reg <= 1'b0;
         ack_ours_reg  <= 1'b0;
         tx_reg        <= 8'h00;
         sda_oe_reg    <= 1'b0;
      end
      // release the data line in power-down
      else if (ce_i && !pg_s)
      begin
         state_reg  <= SCB_IDLE;
         sda_oe_reg <= 1'b0;
      end
      else if (start_det)
      begin
         state_reg  <= SCB_ADDR;
         sda_oe_reg <= 1'b0;
      end
      else if (stop_det)
      begin
         state_reg  <= SCB_IDLE;
         sda_oe_reg <= 1'b0;
      end
      else if (byte_end)
      begin
         ack_ours_reg <= 1'b0;
         sda_oe_reg   <= 1'b0;
         unique case (state_reg)
            SCB_ADDR:
            begin
               if (addr_hit)
               begin
                  ack_ours_reg <= 1'b1;
                  sda_oe_reg   <= 1'b1;
                  state_reg    <= shift_reg[0] ? SCB_TX : SCB_CMD;
               end
               else
                  state_reg <= SCB_IDLE;
            end
            SCB_CMD:
            begin
               // mode bit picks the next state
               byte_mode_reg <= shift_reg[`SCB_CMD_MODE_BIT];
               idx_reg       <= shift_reg[6:0];
               ack_ours_reg  <= 1'b1;
               sda_oe_reg    <= 1'b1;
               state_reg     <= shift_reg[`SCB_CMD_MODE_BIT] ? SCB_WDATA : SCB_WCOUNT;
            end
            SCB_WCOUNT:
            begin
               ack_ours_reg <= 1'b1;
               sda_oe_reg   <= 1'b1;
               state_reg    <= SCB_WDATA;
            end
            SCB_WDATA:
            begin
               ack_ours_reg <= 1'b1;
               sda_oe_reg   <= 1'b1;
               idx_reg      <= idx_reg + 7'h01;
            end
            SCB_TX:
               // Free the line so the host can answer
               sda_oe_reg <= 1'b0;
            SCB_IDLE:
               sda_oe_reg <= 1'b0;
         endcase
      end
      else if (ack_end)
      begin
         ack_ours_reg <= 1'b0;
         if (state_reg == SCB_TX && ack_ours_reg)
         begin
            // block read leads with the count
            if (!byte_mode_reg)
            begin
               tx_reg     <= count_byte;
               sda_oe_reg <= !count_byte[7];
            end
            else
            begin
               tx_reg     <= rd_byte;
               sda_oe_reg <= !rd_byte[7];
               idx_reg    <= idx_reg + 7'h01;
            end
         end
         // host ack asks for the next byte
         else if (state_reg == SCB_TX && mack_reg)
         begin
            tx_reg     <= rd_byte;
            sda_oe_reg <= !rd_byte[7];
            idx_reg    <= idx_reg + 7'h01;
         end
         else if (state_reg == SCB_TX)
         begin
            state_reg  <= SCB_IDLE;
            sda_oe_reg <= 1'b0;
         end
         else
            sda_oe_reg <= 1'b0;
      end
      // Shift out the next bit during the clock low phase
      else if (scl_fall && state_reg == SCB_TX && bit_cnt_reg < `SCB_LAST_BIT)
      begin
         tx_reg     <= {tx_reg[6:0], 1'b0};
         sda_oe_reg <= !tx_reg[6];
      end
   end

   // Register writes; read-only and unmapped bits are left alone
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ctrl_reg.oe_low     <= `SCB_OE_BYTE_RST;
         ctrl_reg.oe_high    <= `SCB_OE_BYTE_RST;
         ctrl_reg.hi_en      <= `SCB_HI_EN_RST;
         ctrl_reg.byte_count <= `SCB_BC_RST;
      end
      else if (byte_end && state_reg == SCB_WDATA)
      begin
         unique case (idx_reg)
            `SCB_IDX_PLL_MODE:
               ctrl_reg.hi_en <= shift_reg[`SCB_HI_EN_MSB:`SCB_HI_EN_LSB];
            `SCB_IDX_OE_LOW:
               ctrl_reg.oe_low <= shift_reg;
            `SCB_IDX_OE_HIGH:
               ctrl_reg.oe_high <= shift_reg;
            `SCB_IDX_BYTE_COUNT:
               ctrl_reg.byte_count <= shift_reg[4:0];
            default:
               ctrl_reg.byte_count <= ctrl_reg.byte_count;
         endcase
      end
   end

   // Output gating, registered so gating glitches never reach the drivers
   generate
      genvar g;
      for (g = 0; g < `SCB_NUM_OUTS; g++)
      begin : g_out
         logic en_bit;
         if (g < 8)
            assign en_bit = ctrl_reg.oe_low[g];
         else if (g < 16)
            assign en_bit = ctrl_reg.oe_high[g - 8];
         else
            assign en_bit = ctrl_reg.hi_en[g - 16];
         // pin-gated outputs need the pin low
         if (g >= `SCB_PIN_GATED_LO && g <= `SCB_PIN_GATED_HI)
         begin : g_pin
            assign out_en_next[g] = pg_s && en_bit && !pin_s[g - `SCB_PIN_GATED_LO];
         end
         else
         begin : g_free
            assign out_en_next[g] = pg_s && en_bit;
         end
      end
   endgenerate

   // One register for all enables, so each bit has a single driver
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         out_en_reg <= 19'h00000;
      else if (ce_i)
         out_en_reg <= out_en_next;
   end

   // Open-drain data pin only ever pulls low
   assign sda_o                  = 1'b0;
   assign sda_oe_o               = sda_oe_reg;
   assign diff_clock_output_en_o = out_en_reg;

   // Checks kept beside the logic
   a_write_ack_drive: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      byte_end && pg_s && (state_reg == SCB_WDATA || state_reg == SCB_WCOUNT) |=> sda_oe_o)
      else $error("write byte not acknowledged");

   a_cmd_index_load: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      byte_end && pg_s && state_reg == SCB_CMD |=> idx_reg == $past(shift_reg[6:0]))
      else $error("command index not taken");

   a_cmd_mode_flag: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      byte_end && pg_s && state_reg == SCB_CMD
      |=> byte_mode_reg == $past(shift_reg[7]) && (state_reg == SCB_WCOUNT) != byte_mode_reg)
      else $error("command mode bit misread");

   a_freq_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      strap_done_reg && $past(strap_done_reg) |-> $stable(strap_reg))
      else $error("latched strap changed");

   a_reserved_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      reg_read(`SCB_IDX_RSVD, strap_reg, ctrl_reg, pin_s) == 8'h00)
      else $error("reserved register not zero");

   a_pin_gate: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      ce_i && (!ctrl_reg.oe_low[5] || pin_s[0]) |=> !diff_clock_output_en_o[5])
      else $error("gated output enabled wrongly");

   a_power_down_input_release: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      ce_i && !pg_s |=> !sda_oe_o && state_reg == SCB_IDLE && diff_clock_output_en_o == '0)
      else $error("bus or outputs active in power-down");

   a_count_range: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      ack_end && state_reg == SCB_TX && ack_ours_reg && !byte_mode_reg
      |=> tx_reg != 8'h00 && tx_reg < 8'h21)
      else $error("block read count out of range");

   a_index_step: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      byte_end && pg_s && state_reg == SCB_WDATA |=> idx_reg == $past(idx_reg) + 7'h01)
      else $error("index did not advance");

endmodule // scb_regs

`default_nettype wire

// *** testbench/scb_host.sv ***
`timescale 1ns/1ns
`default_nettype none

module scb_host
(
   // System clock
   input  wire logic mclk_i,
   // Bus wires
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_low_o
);

   // Idle bus: clock stands high, data released to the pull-up
   initial
   begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end

   // Hold one bus level for n system clocks, changed just after a falling edge
   task automatic phase(input logic c, input logic d, input int n);
      scl_o = c;
      sda_low_o = d;
      repeat (n) @(negedge mclk_i);
   endtask

   // Start or repeated start; data is released first, with the clock left at its present level
   task automatic start_c();
      phase(scl_o, 1'b0, 3);
      phase(1'b1, 1'b0, 6);
      phase(1'b1, 1'b1, 6);
      phase(1'b0, 1'b1, 3);
   endtask

   task automatic stop_c();
      phase(1'b0, 1'b1, 3);
      phase(1'b1, 1'b1, 6);
      phase(1'b1, 1'b0, 6);
   endtask

   // Eight bits MSB first, then the answer slot; send 0xFF to read
   task automatic byte_x(input logic [7:0] d, input logic nak,
                         output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--)
      begin
         // Data moves mid low phase, well clear of both clock edges
         phase(1'b0, ~d[i], 3);
         phase(1'b1, ~d[i], 3);
         q[i] = sda_i;
         phase(1'b1, ~d[i], 3);
         phase(1'b0, ~d[i], 3);
      end
      phase(1'b0, ~nak, 3);
      phase(1'b1, ~nak, 3);
      ack = ~sda_i;
      phase(1'b1, ~nak, 3);
      phase(1'b0, ~nak, 3);
   endtask

endmodule // scb_host

`default_nettype wire

// *** testbench/scb_regs_tb.sv ***
`timescale 1ns/1ns
`default_nettype none

module scb_regs_tb;
   import scb_pkg::*;

   typedef logic [7:0] scb_byte_q_t[$];

   // Pins and expected register image
   logic              mclk;
   logic              rst_n;
   logic              pg;
   logic              fs_s;
   logic [1:0]        pll_s;
   logic [7:0]        pins;
   logic [6:0]        dev_addr;
   wire  logic        scl;
   wire  logic        host_low;
   wire  logic        sda_line;
   wire  logic        sda_out;
   wire  logic        sda_oe;
   wire  logic [18:0] en;
   wire  scb_strap_t  strap;
   logic [7:0]        e_low;
   logic [7:0]        e_high;
   logic [2:0]        e_hi;
   logic [4:0]        e_bc;
   logic [1:0]        e_pll;
   logic              e_freq;
   logic [7:0]        rq [0:8];
   logic [7:0]        v;
   logic [7:0]        w;
   logic              a;
   logic [1:0]        codes [0:2];
   int                n_mismatch;
   int                n_compared;
   int                cyc;
   int                seed;

   // Open-drain data line with pull-up
   assign sda_line = ~((sda_oe & ~sda_out) | host_low);

   scb_regs scb_regs_i
   (
      .mclk_i                 (mclk),
      .rst_n_i                (rst_n),
      .ce_i                   (1'b1),
      .scl_i                  (scl),
      .sda_i                  (sda_line),
      .sda_o                  (sda_out),
      .sda_oe_o               (sda_oe),
      .dev_addr_i             (dev_addr),
      .power_good_strobe_i    (pg),
      .freq_select_strap_i    (fs_s),
      .pll_bandwidth_strap_i  (pll_s),
      .oe_pin_n_i             (pins),
      .diff_clock_output_en_o (en),
      .strap_o                (strap)
   );

   scb_host scb_host_i
   (
      .mclk_i    (mclk),
      .sda_i     (sda_line),
      .scl_o     (scl),
      .sda_low_o (host_low)
   );

   // 20 MHz system clock
   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // Hang guard, well above the few tens of thousands of cycles needed
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 90000)
      begin
         n_mismatch++;
         wrap_up();
      end
   end

   task automatic wrap_up();
      if (n_mismatch == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wait_c(input int n);
      repeat (n) @(negedge mclk);
   endtask

   // Expected readback of one register index
   function automatic logic [7:0] reg_val(input int i);
      case (i)
         0: return {e_pll, e_hi, 2'b00, e_freq};
         1: return e_low;
         2: return e_high;
         3: return pins;
         7: return {3'h0, e_bc};
         default: return 8'h00;
      endcase
   endfunction

   // Expected enables; outputs 5..12 also need their pin low
   function automatic logic [18:0] exp_en();
      logic [18:0] e;
      e = {e_hi, e_high, e_low};
      e[12:5] = e[12:5] & ~pins;
      return e;
   endfunction

   task automatic send(input logic [7:0] b);
      logic [7:0] x;
      logic       k;
      scb_host_i.byte_x(b, 1'b1, x, k);
      chk(k, 1'b1);
   endtask

   task automatic wr(input logic [7:0] cmd, input scb_byte_q_t d);
      scb_host_i.start_c();
      send({dev_addr, 1'b0});
      send(cmd);
      foreach (d[i])
         send(d[i]);
      scb_host_i.stop_c();
   endtask

   task automatic rd(input logic [7:0] cmd, input int n);
      logic k;
      scb_host_i.start_c();
      send({dev_addr, 1'b0});
      send(cmd);
      scb_host_i.start_c();
      send({dev_addr, 1'b1});
      for (int i = 0; i < n; i++)
         scb_host_i.byte_x(8'hFF, i == n - 1, rq[i], k);
      scb_host_i.stop_c();
   endtask

   // Reset, straps presented, then power good raised to latch them
   task automatic pwr_up(input logic [1:0] pll, input logic fs);
      rst_n = 1'b0;
      pg = 1'b0;
      pll_s = pll;
      fs_s = fs;
      wait_c(5);
      rst_n = 1'b1;
      wait_c(2);
      pg = 1'b1;
      wait_c(8);
      e_pll = pll;
      e_freq = fs;
      e_low = 8'hFF;
      e_high = 8'hFF;
      e_hi = 3'h7;
      e_bc = 5'h08;
   endtask

   initial
   begin
      seed = 32'h77B2;
      rst_n = 1'b0;
      pg = 1'b0;
      fs_s = 1'b0;
      pll_s = 2'b00;
      pins = 8'h00;
      dev_addr = 7'h00;
      codes = '{2'b00, 2'b01, 2'b11};
      #1;
      dev_addr = $random(seed);
      // Every strap code, defaults read back by a block read from index 0
      for (int k = 0; k < 3; k++)
      begin
         pwr_up(codes[k], k[0]);
         chk(strap, {e_pll, e_freq});
         rd(8'h00, 9);
         chk(rq[0], 8'h08);
         for (int i = 0; i < 8; i++)
            chk(rq[i + 1], reg_val(i));
         chk(en, exp_en());
      end
      // Random pins, byte and block writes, read-only bits of index 0
      for (int k = 0; k < 6; k++)
      begin
         pins = $random(seed);
         wait_c(6);
         rd(8'h83, 1);
         chk(rq[0], pins);
         chk(en, exp_en());
         v = $random(seed);
         wr(8'h81, {v});
         e_low = v;
         chk(en, exp_en());
         v = $random(seed);
         w = $random(seed);
         wr(8'h01, {8'h02, v, w});
         e_low = v;
         e_high = w;
         chk(en, exp_en());
         v = $random(seed);
         wr(8'h80, {v});
         e_hi = v[5:3];
         rd(8'h80, 1);
         chk(rq[0], reg_val(0));
         chk(en, exp_en());
      end
      // Writes to the pin readback and reserved bytes are ignored
      wr(8'h03, {8'h02, 8'hFF, 8'hFF});
      rd(8'h83, 1);
      chk(rq[0], pins);
      rd(8'h84, 1);
      chk(rq[0], 8'h00);
      // Smallest block count
      v = $random(seed);
      wr(8'h02, {8'h01, v});
      e_high = v;
      chk(en, exp_en());
      // Shorter read length, then a zero count that still sends one byte
      wr(8'h87, {8'h03});
      e_bc = 5'h03;
      rd(8'h01, 4);
      chk(rq[0], 8'h03);
      for (int i = 1; i < 4; i++)
         chk(rq[i], reg_val(i));
      wr(8'h87, {8'h00});
      rd(8'h02, 2);
      chk(rq[0], 8'h01);
      chk(rq[1], e_high);
      // Power-down: outputs off, bus ignored, straps and registers kept
      pg = 1'b0;
      fs_s = ~fs_s;
      pll_s = 2'b01;
      wait_c(6);
      chk(en, 19'h0);
      scb_host_i.start_c();
      scb_host_i.byte_x({dev_addr, 1'b0}, 1'b1, v, a);
      chk(a, 1'b0);
      scb_host_i.stop_c();
      pg = 1'b1;
      wait_c(8);
      chk(strap, {e_pll, e_freq});
      chk(en, exp_en());
      rd(8'h81, 1);
      chk(rq[0], e_low);
      wrap_up();
   end

endmodule // scb_regs_tb

`default_nettype wire
